// ### rtl/isc_regs.vh
// Register map, field positions, reset values and timing counts of the
// two-wire slave control block. Definitions only; included by the RTL.
`ifndef ISC_REGS_VH
`define ISC_REGS_VH

// Register byte offsets on the peripheral bus
`define ISC_OFF_CTRLP 6'h00
`define ISC_OFF_CTRLS 6'h04
`define ISC_OFF_SYNC 6'h1C
`define ISC_OFF_DATA 6'h28
`define ISC_RST_CTRL 32'h00000000

// Primary control fields
`define ISC_B_SOFT_RESET 0
`define ISC_B_ENABLE 1
`define ISC_F_MODE 4:2
`define ISC_B_STBY 7
`define ISC_B_FOURW 16
`define ISC_F_HOLD 21:20
`define ISC_B_CUMTO 23
`define ISC_F_SPEED 25:24
`define ISC_B_STRETCH_AFTER_ACK_SEL 27
`define ISC_B_LOWTO 30
`define ISC_MODE_SLAVE 3'h4

// Secondary control fields
`define ISC_B_AUTO_ACK_ON_READ_EN 8
`define ISC_F_CMD 17:16
`define ISC_B_ACK_RESPONSE_SEL 18
`define ISC_CMD_DONE 2'h2
`define ISC_CMD_NEXT 2'h3

// Timing: clock period and time-out limits
`define ISC_CLK_NS 50
`define ISC_LOWTO_MS 25
`define ISC_CUMTO_MS 25
`define ISC_LOWTO_CYC (`ISC_LOWTO_MS * 1000000 / `ISC_CLK_NS)
`define ISC_CUMTO_CYC (`ISC_CUMTO_MS * 1000000 / `ISC_CLK_NS)
// Hold windows in cycles: least time of each window, rounded up
`define ISC_HOLD1_CYC 4'h1
`define ISC_HOLD2_CYC 4'h6
`define ISC_HOLD3_CYC 4'h8
`define ISC_SYNC_CYC 4'h4
`define ISC_FIFO_W 8
`define ISC_FIFO_D 32

`endif

// ### rtl/isc_slave.v
// Two-wire slave port with its control registers and a receive FIFO.
// Assumes a zero-wait peripheral bus on clk_sys and open-drain pads
// outside that resolve the line levels from the output enables.
`timescale 1ns/10ps
`include "isc_regs.vh"

module isc_fifo #(
    parameter W = 8,
    parameter D = 32,
    parameter AW = 5
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Fill side
    input wire inValid,
    output wire inReady,
    input wire [W-1:0] inData,
    // Drain side
    output wire outValid,
    input wire outReady,
    output wire [W-1:0] outData
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wrPtr_q;
    reg [AW-1:0] rdPtr_q;
    reg [AW:0] count_q;
    wire push = inValid & inReady;
    wire pop = outValid & outReady;

    // Full and empty come straight from the occupancy count
    assign inReady = (count_q != D);
    assign outValid = (count_q != 0);
    assign outData = mem[rdPtr_q];

    // Storage has no reset; only pointers and count need a defined state
    always @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointer and count update
    always @(posedge clk_sys) begin
        if (rst) begin
            wrPtr_q <= {AW{1'b0}};
            rdPtr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) wrPtr_q <= wrPtr_q + 1'b1;
            if (pop) rdPtr_q <= rdPtr_q + 1'b1;
            if (push & ~pop) count_q <= count_q + 1'b1;
            else if (pop & ~push) count_q <= count_q - 1'b1;
        end
    end
endmodule // isc_fifo

module isc_slave #(
    parameter LOW_TO_CYC = `ISC_LOWTO_CYC,
    parameter CUM_TO_CYC = `ISC_CUMTO_CYC
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Peripheral bus
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [5:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Serial pins, open drain
    input wire sclIn,
    output wire sclOut,
    output wire sclOe,
    input wire sdaIn,
    output wire sdaOut,
    output wire sdaOe,
    // System side
    input wire [6:0] slaveAddr,
    input wire standbySleep,
    input wire wakeEnable,
    output reg wakeReq,
    output wire fourWireSel,
    output wire [1:0] speedClass,
    output wire portEnabled,
    output wire byteReadyFlag,
    output wire addressHitFlag,
    output wire stopReceivedFlag
);
    localparam S_IDLE = 4'h1;
    localparam S_SHIFT = 4'h2;
    localparam S_WAIT = 4'h4;
    localparam S_ACK = 4'h8;

    // Byte-lane merge, used by the primary control register only
    function [31:0] laneMerge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            laneMerge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) laneMerge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    // Control state
    reg [31:0] ctrlP_q;
    reg ackSel_q;
    reg autoAck_q;
    reg enActive_q;
    reg enBusy_q;
    reg swBusy_q;
    reg [3:0] syncCnt_q;
    reg byteRdy_q;
    reg addrHit_q;
    reg stopRx_q;
    // Serial engine state
    reg [2:0] sclSync_q;
    reg [2:0] sdaSync_q;
    reg [3:0] state_q;
    reg [3:0] bitCnt_q;
    reg [7:0] shift_q;
    reg isAddr_q;
    reg nacked_q;
    reg seen_q;
    reg inFrame_q;
    reg sawRise_q;
    reg sdaWant_q;
    reg sdaDrv_q;
    reg [3:0] holdCnt_q;
    reg [3:0] holdCyc;
    reg [18:0] lowCnt_q;
    reg [18:0] cumCnt_q;
    // Receive FIFO handshake and head byte
    wire fifoReady;
    wire fifoValid;
    wire [7:0] fifoData;

    // Bus decode; zero-wait, errors only for writes during soft reset
    wire acc = psel & penable;
    wire wrAcc = acc & pwrite & ~swBusy_q;
    wire hitP = (paddr == `ISC_OFF_CTRLP);
    wire hitS = (paddr == `ISC_OFF_CTRLS);
    wire hitD = (paddr == `ISC_OFF_DATA);
    wire [31:0] mergeP = laneMerge(ctrlP_q, pwdata, pstrb);
    wire swSet = wrAcc & hitP & pstrb[0] & pwdata[`ISC_B_SOFT_RESET];
    wire lockOpen = ~enActive_q & ~ctrlP_q[`ISC_B_ENABLE];
    wire [1:0] cmdWr = pstrb[2] ? pwdata[`ISC_F_CMD] : 2'h0;
    wire cmdGo = wrAcc & hitS & cmdWr[1];
    wire dataRd = acc & ~pwrite & hitD & ~swBusy_q;
    wire smartGo = dataRd & autoAck_q;
    wire swGo = cmdGo | smartGo;
    wire swDone = swBusy_q & (syncCnt_q == `ISC_SYNC_CYC);
    wire rstAll = rst | swDone;

    assign pready = 1'b1;
    assign pslverr = acc & pwrite & swBusy_q;

    // Control register writes, enable and soft-reset synchronisation
    always @(posedge clk_sys) begin
        if (rstAll) begin
            ctrlP_q <= `ISC_RST_CTRL;
            ackSel_q <= 1'b0;
            autoAck_q <= 1'b0;
            enActive_q <= 1'b0;
            enBusy_q <= 1'b0;
            swBusy_q <= 1'b0;
            syncCnt_q <= 4'h0;
        end else if (swSet) begin
            swBusy_q <= 1'b1;
            ctrlP_q[`ISC_B_SOFT_RESET] <= 1'b1;
            syncCnt_q <= 4'h0;
        end else if (swBusy_q) begin
            syncCnt_q <= syncCnt_q + 4'h1;
        end else begin
            if (wrAcc & hitP) begin
                if (lockOpen) begin
                    ctrlP_q <= mergeP & 32'h4BB1009C;
                end
                if (pstrb[0]) begin
                    ctrlP_q[`ISC_B_ENABLE] <= pwdata[`ISC_B_ENABLE];
                    enBusy_q <= 1'b1;
                    syncCnt_q <= 4'h0;
                end
            end else if (enBusy_q) begin
                syncCnt_q <= syncCnt_q + 4'h1;
                if (syncCnt_q == `ISC_SYNC_CYC) begin
                    enActive_q <= ctrlP_q[`ISC_B_ENABLE];
                    enBusy_q <= 1'b0;
                end
            end
            if (wrAcc & hitS) begin
                if (pstrb[2]) ackSel_q <= pwdata[`ISC_B_ACK_RESPONSE_SEL];
                if (pstrb[1] & lockOpen) autoAck_q <= pwdata[`ISC_B_AUTO_ACK_ON_READ_EN];
            end
        end
    end

    // Read data is captured in the setup phase; reset values while busy
    always @(posedge clk_sys) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= 32'h00000000;
            if (!swBusy_q) begin
                case (paddr)
                    `ISC_OFF_CTRLP: prdata <= ctrlP_q;
                    `ISC_OFF_CTRLS: prdata <= {13'h0000, ackSel_q, 2'h0,
                        7'h00, autoAck_q, 8'h00};
                    `ISC_OFF_SYNC: prdata <= {30'h00000000, enBusy_q,
                        swBusy_q};
                    `ISC_OFF_DATA: prdata <= {24'h000000,
                        fifoValid ? fifoData : 8'h00};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Two-flop synchronisers; stage 2 and 3 feed the edge finders
    always @(posedge clk_sys) begin
        if (rst) begin
            sclSync_q <= 3'h7;
            sdaSync_q <= 3'h7;
        end else begin
            sclSync_q <= {sclSync_q[1:0], sclIn};
            sdaSync_q <= {sdaSync_q[1:0], sdaIn};
        end
    end

    wire scl = sclSync_q[1];
    wire sda = sdaSync_q[1];
    wire sclRise = scl & ~sclSync_q[2];
    wire sclFall = ~scl & sclSync_q[2];
    wire startSeen = scl & sclSync_q[2] & ~sda & sdaSync_q[2];
    wire stopSeen = scl & sclSync_q[2] & sda & ~sdaSync_q[2];
    wire active = enActive_q & (ctrlP_q[`ISC_F_MODE] == `ISC_MODE_SLAVE);
    wire dropRx = standbySleep & ~ctrlP_q[`ISC_B_STBY];
    wire stretchLate = ctrlP_q[`ISC_B_STRETCH_AFTER_ACK_SEL];
    wire lowTo = ctrlP_q[`ISC_B_LOWTO] & (lowCnt_q == LOW_TO_CYC);
    wire cumTo = ctrlP_q[`ISC_B_CUMTO] & (cumCnt_q > CUM_TO_CYC);
    wire byteDone = (bitCnt_q == 4'h8) & ~scl;
    wire canPush = isAddr_q | fifoReady;
    wire pushByte = (state_q == S_SHIFT) & byteDone & ~isAddr_q & fifoReady;
    wire addrMatch = (state_q == S_SHIFT) & byteDone & isAddr_q &
        (shift_q[7:1] == slaveAddr) & ~shift_q[0];

    // Low-time counters; flags are untouched by either time-out
    always @(posedge clk_sys) begin
        if (rstAll | ~active) begin
            lowCnt_q <= 19'h00000;
            cumCnt_q <= 19'h00000;
            inFrame_q <= 1'b0;
        end else begin
            lowCnt_q <= (scl | lowTo) ? 19'h00000 : lowCnt_q + 19'h00001;
            if (startSeen) inFrame_q <= 1'b1;
            else if (stopSeen | cumTo) inFrame_q <= 1'b0;
            if (startSeen | ~inFrame_q) cumCnt_q <= 19'h00000;
            else if (~scl & ~cumTo) cumCnt_q <= cumCnt_q + 19'h00001;
        end
    end

    // Serial engine: address, data shift, software stretch, ack bit
    always @(posedge clk_sys) begin
        if (rstAll | ~active | lowTo | cumTo | dropRx) begin
            state_q <= S_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            isAddr_q <= 1'b0;
            nacked_q <= 1'b0;
            sawRise_q <= 1'b0;
            sdaWant_q <= 1'b0;
        end else if (startSeen) begin
            state_q <= S_SHIFT;
            bitCnt_q <= 4'h0;
            isAddr_q <= 1'b1;
            sdaWant_q <= 1'b0;
        end else if (stopSeen) begin
            state_q <= S_IDLE;
            sdaWant_q <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: state_q <= S_IDLE;
                S_SHIFT: begin
                    if (sclRise && bitCnt_q != 4'h8) begin
                        shift_q <= {shift_q[6:0], sda};
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end else if (byteDone & canPush) begin
                        if (isAddr_q & ~addrMatch) begin
                            state_q <= S_IDLE;
                        end else if (stretchLate) begin
                            state_q <= S_ACK;
                            nacked_q <= ackSel_q;
                            sdaWant_q <= ~ackSel_q;
                            sawRise_q <= 1'b0;
                        end else begin
                            state_q <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    if (swGo & stretchLate) begin
                        state_q <= nacked_q ? S_IDLE : S_SHIFT;
                        bitCnt_q <= 4'h0;
                        isAddr_q <= 1'b0;
                    end else if (swGo) begin
                        state_q <= S_ACK;
                        nacked_q <= ackSel_q;
                        sdaWant_q <= ~ackSel_q;
                        sawRise_q <= 1'b0;
                    end
                end
                S_ACK: begin
                    if (sclRise) sawRise_q <= 1'b1;
                    if (sclFall & sawRise_q) begin
                        sdaWant_q <= 1'b0;
                        bitCnt_q <= 4'h0;
                        if (stretchLate) begin
                            state_q <= S_WAIT;
                        end else begin
                            state_q <= nacked_q ? S_IDLE : S_SHIFT;
                            isAddr_q <= 1'b0;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Data line changes wait out the selected hold after the clock falls
    always @(posedge clk_sys) begin
        if (rstAll) begin
            sdaDrv_q <= 1'b0;
            holdCnt_q <= 4'h0;
        end else if (sdaWant_q == sdaDrv_q) begin
            holdCnt_q <= 4'h0;
        end else if (holdCnt_q >= holdCyc) begin
            sdaDrv_q <= sdaWant_q;
            holdCnt_q <= 4'h0;
        end else begin
            holdCnt_q <= holdCnt_q + 4'h1;
        end
    end

    // Hold window in cycles, least times rounded up
    always @* begin
        case (ctrlP_q[`ISC_F_HOLD])
            2'h1: holdCyc = `ISC_HOLD1_CYC;
            2'h2: holdCyc = `ISC_HOLD2_CYC;
            2'h3: holdCyc = `ISC_HOLD3_CYC;
            default: holdCyc = 4'h0;
        endcase
    end

    // Flags: set by the engine, cleared by commands; set wins the tie
    always @(posedge clk_sys) begin
        if (rstAll) begin
            byteRdy_q <= 1'b0;
            addrHit_q <= 1'b0;
            stopRx_q <= 1'b0;
            seen_q <= 1'b0;
            wakeReq <= 1'b0;
        end else begin
            byteRdy_q <= pushByte | (byteRdy_q & ~cmdGo);
            addrHit_q <= addrMatch | (addrHit_q & ~cmdGo);
            stopRx_q <= (stopSeen & seen_q) | (stopRx_q & ~cmdGo);
            if (addrMatch) seen_q <= 1'b1;
            else if (stopSeen) seen_q <= 1'b0;
            wakeReq <= addrMatch & standbySleep & wakeEnable;
        end
    end

    // Received data bytes; a full FIFO holds the clock low before ack
    isc_fifo #(
        .W(`ISC_FIFO_W),
        .D(`ISC_FIFO_D),
        .AW(5)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rstAll),
        .inValid(pushByte),
        .inReady(fifoReady),
        .inData(shift_q),
        .outValid(fifoValid),
        .outReady(dataRd),
        .outData(fifoData)
    );

    // Clock is stretched in the wait state or while the FIFO is full;
    // the ack level settles first, since a data change with the clock
    // high would read as START or STOP
    assign sclOe = (state_q == S_WAIT) |
        ((state_q == S_ACK) & (sdaDrv_q != sdaWant_q)) |
        ((state_q == S_SHIFT) & byteDone & ~canPush);
    assign sclOut = 1'b0;
    assign sdaOe = sdaDrv_q;
    assign sdaOut = 1'b0;
    assign fourWireSel = ctrlP_q[`ISC_B_FOURW];
    assign speedClass = ctrlP_q[`ISC_F_SPEED];
    assign portEnabled = enActive_q;
    assign byteReadyFlag = byteRdy_q;
    assign addressHitFlag = addrHit_q;
    assign stopReceivedFlag = stopRx_q;
endmodule // isc_slave

// ### dv/isc_slave_properties.sv
// Port checker of the two-wire slave control block.
// Assumes it is bound onto isc_slave; one clock, sync active-high reset.
`timescale 1ns/10ps
module isc_slave_properties (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Peripheral bus
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [5:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire pready,
    input wire pslverr,
    // System side
    input wire standbySleep,
    input wire wakeEnable,
    input wire wakeReq,
    input wire fourWireSel,
    input wire [1:0] speedClass,
    input wire portEnabled,
    input wire byteReadyFlag,
    input wire addressHitFlag,
    input wire stopReceivedFlag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Accepted writes; refused ones carry pslverr and change nothing
    wire wrAcc = psel && penable && pwrite && !pslverr;
    wire wrP = wrAcc && paddr == 6'h00;
    wire wrS = wrAcc && paddr == 6'h04;

    chk_ready_always: assert property (pready)
        else $error("bus access stalled");
    chk_err_write: assert property (pslverr
        |-> psel && penable && pwrite)
        else $error("error response outside a write");
    chk_cmd_clears: assert property (wrS && pstrb[2] && pwdata[17]
        |=> !byteReadyFlag && !addressHitFlag && !stopReceivedFlag)
        else $error("command left a flag set");
    chk_enable_sync: assert property (wrP && pstrb[0]
        && pwdata[1:0] == 2'b10 |-> ##[1:8] portEnabled)
        else $error("port not enabled after sync delay");
    chk_soft_reset_off: assert property (wrP && pstrb[0] && pwdata[0]
        |-> ##[1:8] (!portEnabled && !fourWireSel && speedClass == 2'h0))
        else $error("soft reset did not clear the port");
    chk_wake_cause: assert property (wakeReq
        |-> $past(standbySleep) && $past(wakeEnable))
        else $error("wake request without standby");
    chk_wake_pulse: assert property (wakeReq |=> !wakeReq)
        else $error("wake request longer than a cycle");
    chk_four_prot: assert property ($rose(fourWireSel)
        |-> !$past(portEnabled))
        else $error("protected field changed while enabled");
    chk_speed_write: assert property ($changed(speedClass)
        && speedClass != 2'h0 |-> $past(wrP && pstrb[3]))
        else $error("speed class changed without a write");
endmodule // isc_slave_properties

// ### dv/isc_master_model.sv
// Two-wire bus master model: drives pull-down enables only.
// Assumes the bench resolves both lines with pull-ups.
`timescale 1ns/10ps
module isc_master_model (
    // Resolved line levels
    input wire sclLine,
    input wire sdaLine,
    // Pull-down enables
    output reg sclLow,
    output reg sdaLow
);
    // Idle bus, clock stands still between frames
    initial begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
    end

    // Release the clock, then wait out any stretch (bounded)
    task sclRise;
        integer n;
        begin
            sclLow = 1'b0;
            for (n = 0; n < 1000 && sclLine !== 1'b1; n = n + 1)
                #50;
        end
    endtask

    // Data falls while the clock is high
    task startCond;
        begin
            #200 sdaLow = 1'b1;
            #200 sclLow = 1'b1;
        end
    endtask

    // Eight bits first-high, then the ninth clock samples the answer
    task sendByte(input [7:0] b, output ack);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                #100 sdaLow = ~b[i];
                #100 sclRise;
                #200 sclLow = 1'b1;
            end
            #100 sdaLow = 1'b0;
            #100 sclRise;
            #100 ack = sdaLine;
            #100 sclLow = 1'b1;
        end
    endtask

    // Data rises while the clock is high, then both lines released
    task stopCond;
        begin
            #100 sdaLow = 1'b1;
            #100 sclRise;
            #200 sdaLow = 1'b0;
            #200;
        end
    endtask
endmodule // isc_master_model

// ### dv/isc_slave_tb.sv
// Self-checking bench of the two-wire slave control block.
// Assumes isc_slave, its checker and the master model are compiled.
`timescale 1ns/10ps
module isc_slave_tb;
    reg clk_sys, rst, psel, penable, pwrite, standbySleep, wakeEnable;
    reg e, ack;
    reg [5:0] paddr;
    reg [31:0] pwdata, rd;
    reg [3:0] pstrb;
    wire [31:0] prdata;
    wire pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, wakeReq, mScl;
    wire fourWireSel, portEnabled, byteReadyFlag, addressHitFlag, mSda;
    wire stopReceivedFlag;
    wire [1:0] speedClass;
    integer errTotal, compares, wakes, n;
    localparam [6:0] ADDR = 7'h2A;
    // Open-drain lines with pull-ups
    wire sclLine = ~(sclOe | mScl);
    wire sdaLine = ~(sdaOe | mSda);

    // Short time-outs keep the run brief
    isc_slave #(.LOW_TO_CYC(200), .CUM_TO_CYC(400)) i_isc_slave (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .slaveAddr(ADDR), .standbySleep(standbySleep),
        .wakeEnable(wakeEnable), .wakeReq(wakeReq),
        .fourWireSel(fourWireSel), .speedClass(speedClass),
        .portEnabled(portEnabled), .byteReadyFlag(byteReadyFlag),
        .addressHitFlag(addressHitFlag),
        .stopReceivedFlag(stopReceivedFlag));
    isc_master_model i_isc_master_model (.sclLine(sclLine),
        .sdaLine(sdaLine), .sclLow(mScl), .sdaLow(mSda));

    // 20 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Count wake pulses
    always @(posedge clk_sys) begin
        if (wakeReq === 1'b1)
            wakes = wakes + 1;
    end

    task check(input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                errTotal = errTotal + 1;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    // Setup then access; answer taken at the closing edge
    task apbWr(input [5:0] a, input [31:0] d, input [3:0] s, output err);
        begin
            @(posedge clk_sys);
            #1 psel = 1'b1;
            pwrite = 1'b1;
            paddr = a;
            pwdata = d;
            pstrb = s;
            @(posedge clk_sys);
            #1 penable = 1'b1;
            @(posedge clk_sys);
            err = pslverr;
            #1 psel = 1'b0;
            penable = 1'b0;
        end
    endtask

    task apbRd(input [5:0] a, output [31:0] d);
        begin
            @(posedge clk_sys);
            #1 psel = 1'b1;
            pwrite = 1'b0;
            paddr = a;
            @(posedge clk_sys);
            #1 penable = 1'b1;
            @(posedge clk_sys);
            d = prdata;
            #1 psel = 1'b0;
            penable = 1'b0;
        end
    endtask

    // Bounded wait until the slave holds the clock
    task waitStretch;
        begin
            for (n = 0; n < 2000 && sclOe !== 1'b1; n = n + 1)
                @(posedge clk_sys);
            repeat (2) @(posedge clk_sys);
            #1;
        end
    endtask

    task t_fields;
        begin
            apbRd(6'h00, rd);
            check(rd, 32'h0);
            apbRd(6'h3C, rd);
            check(rd, 32'h0);
            apbWr(6'h00, 32'hFFFFFFFC, 4'hF, e);
            apbRd(6'h00, rd);
            check(rd, 32'h4BB1009C);
            check({fourWireSel, speedClass}, 3'h7);
            apbWr(6'h00, 32'h0, 4'h4, e);
            apbRd(6'h00, rd);
            check(rd, 32'h4B00009C);
            apbWr(6'h04, 32'hFFFFFFFF, 4'hF, e);
            apbRd(6'h04, rd);
            check(rd, 32'h00040100);
        end
    endtask

    task t_enable;
        begin
            apbWr(6'h04, 32'h00000100, 4'hF, e);
            apbWr(6'h00, 32'h41000090, 4'hF, e);
            apbWr(6'h00, 32'h00000092, 4'h1, e);
            apbRd(6'h00, rd);
            check(rd, 32'h41000092);
            apbRd(6'h1C, rd);
            check(rd, 32'h2);
            repeat (8) @(posedge clk_sys);
            apbRd(6'h1C, rd);
            check(rd, 32'h0);
            check(portEnabled, 1'b1);
            apbWr(6'h00, 32'h00010012, 4'hF, e);
            apbRd(6'h00, rd);
            check(rd, 32'h41000092);
            check({fourWireSel, speedClass}, 3'h1);
        end
    endtask

    task t_xfer;
        begin
            i_isc_master_model.startCond;
            fork
                i_isc_master_model.sendByte({ADDR, 1'b0}, ack);
                begin
                    waitStretch;
                    check(addressHitFlag, 1'b1);
                    apbWr(6'h04, 32'h00030000, 4'h4, e);
                    check(addressHitFlag, 1'b0);
                end
            join
            check(ack, 1'b0);
            fork
                i_isc_master_model.sendByte(8'hA5, ack);
                begin
                    waitStretch;
                    apbRd(6'h28, rd);
                    check(rd, 32'hA5);
                end
            join
            check(ack, 1'b0);
            apbWr(6'h04, 32'h00040000, 4'h4, e);
            fork
                i_isc_master_model.sendByte(8'h3C, ack);
                begin
                    waitStretch;
                    apbRd(6'h28, rd);
                    check(rd, 32'h3C);
                end
            join
            check(ack, 1'b1);
            i_isc_master_model.stopCond;
            check(stopReceivedFlag, 1'b1);
            apbWr(6'h04, 32'h00020000, 4'h4, e);
            check({stopReceivedFlag, byteReadyFlag, addressHitFlag}, 0);
        end
    endtask

    task t_timeout;
        begin
            standbySleep = 1'b1;
            wakeEnable = 1'b1;
            apbWr(6'h04, 32'h0, 4'h4, e);
            i_isc_master_model.startCond;
            fork
                i_isc_master_model.sendByte({ADDR, 1'b0}, ack);
                begin
                    waitStretch;
                    repeat (260) @(posedge clk_sys);
                    #1 check(sclOe, 1'b0);
                    check(addressHitFlag, 1'b1);
                end
            join
            check(ack, 1'b1);
            i_isc_master_model.stopCond;
            check(wakes, 1);
            @(posedge clk_sys);
            #1 standbySleep = 1'b0;
        end
    endtask

    // Stretch only after the ack bit; ack is driven without software
    task t_late;
        begin
            apbWr(6'h00, 32'h0, 4'h1, e);
            repeat (8) @(posedge clk_sys);
            apbWr(6'h00, 32'h08000092, 4'h9, e);
            repeat (8) @(posedge clk_sys);
            i_isc_master_model.startCond;
            i_isc_master_model.sendByte({ADDR, 1'b0}, ack);
            check(ack, 1'b0);
            repeat (4) @(posedge clk_sys);
            #1 check(sclOe, 1'b1);
            apbWr(6'h04, 32'h00030000, 4'h4, e);
            check(sclOe, 1'b0);
            i_isc_master_model.stopCond;
        end
    endtask

    task t_soft_reset;
        begin
            apbWr(6'h00, 32'hFFFFFFFF, 4'hF, e);
            check(e, 1'b0);
            apbWr(6'h04, 32'h00040000, 4'h4, e);
            check(e, 1'b1);
            apbRd(6'h00, rd);
            check(rd, 32'h0);
            repeat (8) @(posedge clk_sys);
            apbRd(6'h00, rd);
            check(rd, 32'h0);
            check(portEnabled, 1'b0);
            apbRd(6'h1C, rd);
            check(rd, 32'h0);
            apbRd(6'h04, rd);
            check(rd, 32'h0);
        end
    endtask

    task finish_test;
        begin
            $display("Compares %0d, mismatches %0d", compares, errTotal);
            if (errTotal == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    // Main sequence
    initial begin
        errTotal = 0;
        compares = 0;
        wakes = 0;
        rst = 1'b1;
        {psel, penable, pwrite, standbySleep, wakeEnable} = 5'h00;
        paddr = 6'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        repeat (12) @(posedge clk_sys);
        #1 rst = 1'b0;
        t_fields;
        t_enable;
        t_xfer;
        t_timeout;
        t_late;
        t_soft_reset;
        finish_test;
    end
    // Watchdog well beyond the expected run
    initial begin
        #2000000;
        errTotal = errTotal + 1;
        finish_test;
    end
endmodule // isc_slave_tb

bind isc_slave isc_slave_properties i_isc_slave_properties (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .standbySleep(standbySleep),
    .wakeEnable(wakeEnable), .wakeReq(wakeReq),
    .fourWireSel(fourWireSel), .speedClass(speedClass),
    .portEnabled(portEnabled), .byteReadyFlag(byteReadyFlag),
    .addressHitFlag(addressHitFlag), .stopReceivedFlag(stopReceivedFlag));
